//--- core/sram_host_cfg.svh
// timing constants and pin levels for the async byte sram host
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH
`define SH_CLK_PERIOD_NS   20
`define SH_ACCESS_NS       60
`define SH_ACCESS_CYCLES   ((`SH_ACCESS_NS + `SH_CLK_PERIOD_NS - 1) / `SH_CLK_PERIOD_NS)
`define SH_DEPTH_KB        32
`define SH_ADDR_W          15
`define SH_LANES           4
`define SH_PIN_IDLE        1'b1
`endif

//--- core/sh_pkg.sv
// types for the async byte sram host
package sh_pkg;
  typedef enum logic [1:0] {sh_idle, sh_strobe, sh_recover} sh_state_t;
endpackage

//--- core/sh_host.sv
// word-wide host that drives four byte-lane async srams through their pins
`include "sram_host_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - chip select driven low for the whole access, high otherwise
// - write strobe held low to write the byte bus value
// - output enable driven low only during reads
// - every access is a full 32-bit word, one byte per lane
module sh_host #(
  parameter int SIZE_KILOBYTES = `SH_DEPTH_KB,
  parameter int ADDR_W         = $clog2(SIZE_KILOBYTES * 1024),
  parameter int ACCESS_CYCLES  = `SH_ACCESS_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                req_valid,
  input  wire logic                req_write,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [31:0]         req_wdata,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output logic [31:0]              rsp_rdata,
  output logic [ADDR_W-1:0]        mem_addr,
  output logic                     chip_select_low,
  output logic                     write_strobe_low,
  output logic                     output_drive_low,
  input  wire logic [31:0]         mem_data_in,
  output logic [31:0]              mem_data_out,
  output logic [31:0]              mem_data_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: a request is only looked at in idle, while busy it is left waiting
  sh_pkg::sh_state_t state;
  sh_pkg::sh_state_t next_state;
  logic [7:0]        cnt;
  logic [7:0]        next_cnt;
  logic              is_write;
  logic              take;
  logic              in_strobe;
  logic              in_recover;
  logic              last_beat;

  assign in_strobe  = (state == sh_pkg::sh_strobe);
  assign in_recover = (state == sh_pkg::sh_recover);
  assign take       = (state == sh_pkg::sh_idle) && req_valid;
  assign last_beat  = in_strobe && (cnt == 8'h00);

  // one extra recovery cycle keeps the bus from contending at turnaround
  always_comb begin
    next_state = state;
    unique case (state)
      sh_pkg::sh_idle: begin
        if (req_valid) begin
          next_state = sh_pkg::sh_strobe;
        end
      end
      sh_pkg::sh_strobe: begin
        if (cnt == 8'h00) begin
          next_state = sh_pkg::sh_recover;
        end
      end
      sh_pkg::sh_recover: begin
        next_state = sh_pkg::sh_idle;
      end
      default: begin
        next_state = sh_pkg::sh_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= sh_pkg::sh_idle;
    end else begin
      state <= next_state;
    end
  end

  // 8-bit counter: access lengths above 256 cycles would need a wider one
  always_comb begin
    next_cnt = cnt;
    if (take) begin
      next_cnt = 8'(ACCESS_CYCLES - 1);
    end else if (in_strobe && cnt != 8'h00) begin
      next_cnt = cnt - 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  // direction is remembered for the read sample at the end of the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      is_write <= 1'b0;
    end else if (take) begin
      is_write <= req_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: address and data latched at request, held stable through the strobe
  // address is left in place after release, so no lane sees it move under a strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mem_addr <= '0;
    end else if (take) begin
      mem_addr <= req_addr;
    end
  end

  // select spans the whole strobe; the lanes answer only while it is low
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chip_select_low <= `SH_PIN_IDLE;
    end else if (take) begin
      chip_select_low <= 1'b0;
    end else if (last_beat) begin
      chip_select_low <= `SH_PIN_IDLE;
    end
  end

  // strobe and select rise on the same edge, with data still held there
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      write_strobe_low <= `SH_PIN_IDLE;
    end else if (take) begin
      write_strobe_low <= ~req_write;
    end else if (last_beat) begin
      write_strobe_low <= `SH_PIN_IDLE;
    end
  end

  // output enable stays high on writes so the lanes never fight the host
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      output_drive_low <= `SH_PIN_IDLE;
    end else if (take) begin
      output_drive_low <= req_write;
    end else if (last_beat) begin
      output_drive_low <= `SH_PIN_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte lanes: each lane owns one byte of the word and its own bus drivers
  // the word is split only here; all lanes share address and strobes
  for (genvar lane = 0; lane < `SH_LANES; lane++) begin : g_lane
    logic [7:0] lane_wdata;
    logic [7:0] lane_oe;
    logic [7:0] lane_rdata;

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        lane_wdata <= 8'h00;
      end else if (take) begin
        lane_wdata <= req_wdata[8*lane +: 8];
      end
    end

    // the host lets go of the bus on the last strobe edge, before any read can follow
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        lane_oe <= 8'h00;
      end else if (take) begin
        lane_oe <= {8{req_write}};
      end else if (last_beat) begin
        lane_oe <= 8'h00;
      end
    end

    // read data is sampled on the last strobe cycle, while the lanes still drive
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        lane_rdata <= 8'h00;
      end else if (last_beat && !is_write) begin
        lane_rdata <= mem_data_in[8*lane +: 8];
      end
    end

    assign mem_data_out[8*lane +: 8] = lane_wdata;
    assign mem_data_oe[8*lane +: 8]  = lane_oe;
    assign rsp_rdata[8*lane +: 8]    = lane_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // response: a one-cycle pulse per access, reads and writes alike
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= last_beat;
    end
  end

  // ready marks the idle cycle after recovery; a request held through it is taken next edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= in_recover;
    end
  end

endmodule // sh_host

//--- sim/sh_host_props.sv
// pin-level assertions for the sram host
module sh_props #(
  parameter int ADDR_W = 15
) (
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire logic              req_valid,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              chip_select_low,
  input wire logic              write_strobe_low,
  input wire logic              output_drive_low,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [31:0]       mem_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_held; !chip_select_low [*3] ##1 chip_select_low && rsp_valid; endsequence
  AST_LEN: assert property ($fell(chip_select_low) |-> s_held) else $error("len");
  AST_GO: assert property ($fell(chip_select_low) |-> $past(req_valid)) else $error("go");
  AST_TAKE_ADDR: assert property ($fell(chip_select_low) |-> mem_addr == $past(req_addr))
    else $error("address not the one requested");
  AST_WR: assert property (!write_strobe_low |-> !chip_select_low && &mem_data_oe)
    else $error("wr");
  AST_RD: assert property (!output_drive_low |-> mem_data_oe == 0) else $error("rd");
  AST_OFF: assert property (chip_select_low |-> write_strobe_low && output_drive_low)
    else $error("off");
  AST_ADR: assert property (!$past(chip_select_low) |-> $stable(mem_addr)) else $error("adr");
  AST_RDY: assert property (rsp_valid |=> req_ready && !rsp_valid) else $error("rdy");
endmodule // sh_props

//--- sim/sh_lane.sv
// byte lane model of the async sram; a released bus shows the inverse of the addressed byte
module sh_lane #(
  parameter int AW = 15
) (
  input wire logic [AW-1:0] a,
  input wire logic [7:0]    d,
  input wire logic          cs_l,
  input wire logic          we_l,
  input wire logic          oe_l,
  output logic [7:0]        q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [2**AW];
  logic       wr_on = 1'b0;
  // fixed preload stands in for the data file: every byte starts at zero
  initial begin
    foreach (m[i]) m[i] = 8'h00;
  end
  // byte latched as select or strobe rises, so pins settling in one step cannot glitch a write
  always @(cs_l or we_l) begin
    if (wr_on === 1'b1 && (cs_l || we_l)) m[a] = d;
    wr_on = !cs_l && !we_l;
  end
  always @(cs_l or oe_l or a) q = (!cs_l && !oe_l) ? m[a] : ~m[a];
endmodule // sh_lane

//--- sim/sh_host_tb_top.sv
// self-checking bench for the sram host
module sh_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, srst = 1, req_valid = 0, req_write = 0, req_ready, rsp_valid, p;
  logic chip_select_low, write_strobe_low, output_drive_low;
  logic [14:0] req_addr = 0, mem_addr;
  logic [31:0] req_wdata = 0, rsp_rdata, mem_data_out, mem_data_oe, lq, mem_data_in, ref_m [8];
  logic [32:0] q [$], n;
  int fails = 0, checks = 0, k;
  always #10 ref_clk = ~ref_clk;
  assign mem_data_in = (mem_data_oe & mem_data_out) | (~mem_data_oe & lq);
  sh_host dut (
    .ref_clk          (ref_clk),
    .srst             (srst),
    .req_valid        (req_valid),
    .req_write        (req_write),
    .req_addr         (req_addr),
    .req_wdata        (req_wdata),
    .req_ready        (req_ready),
    .rsp_valid        (rsp_valid),
    .rsp_rdata        (rsp_rdata),
    .mem_addr         (mem_addr),
    .chip_select_low  (chip_select_low),
    .write_strobe_low (write_strobe_low),
    .output_drive_low (output_drive_low),
    .mem_data_in      (mem_data_in),
    .mem_data_out     (mem_data_out),
    .mem_data_oe      (mem_data_oe)
  );
  for (genvar i = 0; i < 4; i++) begin : g_lane
    sh_lane ln (.a(mem_addr), .d(mem_data_out[8*i+:8]), .cs_l(chip_select_low),
      .we_l(write_strobe_low), .oe_l(output_drive_low), .q(lq[8*i+:8]));
  end
  task automatic chk(logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %0t read %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // request stays up while busy, so the host must ignore it until idle
  task automatic op(logic w, logic [2:0] a, logic [31:0] d);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, 12'h000, a, d};
    k = 0;
    do begin p = chip_select_low; @(posedge ref_clk) #1; k++; end
    while (!(p === 1'b1 && chip_select_low === 1'b0) && k < 20);
    if (k == 20) begin fails++; report_and_stop; end
    q.push_back({!w, w ? d : ref_m[a]});
    if (w) ref_m[a] = d;
  endtask
  always @(negedge ref_clk) if (rsp_valid === 1'b1 && q.size() > 0) begin
    n = q.pop_front();
    if (n[32]) chk(rsp_rdata, n[31:0]);
  end
  initial begin
    void'($urandom(32'h7dcfa3ea));
    repeat (20) @(posedge ref_clk);
    #1 srst = 0;
    for (int i = 0; i < 8; i++) op(1'b1, i[2:0], $urandom);
    $display("fill done");
    for (int i = 0; i < 8; i++) op(1'b0, i[2:0], 32'h00000000);
    $display("readback done");
    repeat (40) op(1'($urandom), 3'($urandom), $urandom);
    req_valid = 0;
    for (k = 0; k < 20 && q.size() > 0; k++) @(posedge ref_clk);
    if (q.size() > 0) fails++;
    $display("random done");
    report_and_stop;
  end
endmodule // sh_host_tb_top
bind sh_host sh_props #(.ADDR_W(ADDR_W)) u_props (
  .ref_clk          (ref_clk),
  .srst             (srst),
  .req_valid        (req_valid),
  .req_addr         (req_addr),
  .req_ready        (req_ready),
  .rsp_valid        (rsp_valid),
  .chip_select_low  (chip_select_low),
  .write_strobe_low (write_strobe_low),
  .output_drive_low (output_drive_low),
  .mem_addr         (mem_addr),
  .mem_data_oe      (mem_data_oe)
);
